/* File: src/ebcod_pkg.sv */
// Package for the 8-bit core opcode decoder: opcode patterns, field positions,
// operation classes and timing constants.
// Assumes a core that fetches one 16-bit word per instruction cycle.
package ebcod_pkg;

  // Oscillator and instruction cycle timing
  localparam int          CLK_PERIOD_NS     = 50;
  localparam int          OSC_PER_CYCLE     = 4;
  localparam logic [1:0]  PHASE_LAST        = 2'(OSC_PER_CYCLE - 1);

  // Field positions inside the instruction word
  localparam int          F_DEST            = 9;
  localparam int          F_ACCESS          = 8;
  localparam int          F_BIT_LSB         = 9;
  localparam int          F_FAST            = 0;
  localparam int          F_CALL_FAST       = 8;

  // Fixed words
  localparam logic [15:0] W_NOP             = 16'h0000;
  localparam logic [15:0] W_WDT_CLEAR       = 16'h0004;
  localparam logic [15:0] W_PUSH            = 16'h0005;
  localparam logic [15:0] W_POP             = 16'h0006;
  localparam logic [15:0] W_DAW             = 16'h0007;
  localparam logic [15:0] W_SLEEP           = 16'h0003;
  localparam logic [15:0] W_SWRESET         = 16'h00FF;
  localparam logic [14:0] W_INTERRUPT_RETURN_OP_HI       = 15'h0008;
  localparam logic [14:0] W_RETURN_HI       = 15'h0009;

  // Upper nibbles and longer leading opcode fields
  localparam logic [3:0]  N_SECOND          = 4'hF;
  localparam logic [3:0]  N_MOVE            = 4'hC;
  localparam logic [3:0]  N_REL             = 4'hD;
  localparam logic [3:0]  N_BRANCH          = 4'hE;
  localparam logic [7:0]  B_RETURN_WITH_LITERAL_OP           = 8'h0C;
  localparam logic [7:0]  B_ABSOLUTE_JUMP            = 8'hEF;
  localparam logic [6:0]  B_CALL            = 7'h76;
  localparam logic [5:0]  B_TABLE           = 6'h02;

  // Pointer modes of table access
  typedef enum logic [1:0] {
    TBL_KEEP = 2'b00,
    TBL_POST_INC = 2'b01,
    TBL_POST_DEC = 2'b10,
    TBL_PRE_INC = 2'b11
  } ebcod_tbl_t;

  // Operation classes
  typedef enum logic [5:0] {
    OP_NOP = 6'h00, OP_ADD = 6'h01, OP_ADDC = 6'h02, OP_SUB = 6'h03,
    OP_SUBB = 6'h04, OP_SUBFB = 6'h05, OP_INC = 6'h06, OP_DEC = 6'h07,
    OP_NEG = 6'h08, OP_AND = 6'h09, OP_IOR = 6'h0A, OP_XOR = 6'h0B,
    OP_COM = 6'h0C, OP_CPSEQ = 6'h0D, OP_CPSGT = 6'h0E, OP_CPSLT = 6'h0F,
    OP_DECSZ = 6'h10, OP_INCSZ = 6'h11, OP_DECSNZ = 6'h12, OP_INCSNZ = 6'h13,
    OP_BCLR = 6'h14, OP_BSET = 6'h15, OP_BTGL = 6'h16, OP_BTSC = 6'h17,
    OP_BTSS = 6'h18, OP_BCOND = 6'h19, OP_BRA = 6'h1A, OP_RELATIVE_SUBROUTINE_CALL = 6'h1B,
    OP_CALL = 6'h1C, OP_ABSOLUTE_JUMP = 6'h1D, OP_FILE_TO_FILE_MOVE = 6'h1E, OP_WDT = 6'h1F,
    OP_PUSH = 6'h20, OP_POP = 6'h21, OP_DAW = 6'h22, OP_RESET = 6'h23,
    OP_INTERRUPT_RETURN_OP = 6'h24, OP_RETURN = 6'h25, OP_RETURN_WITH_LITERAL_OP = 6'h26, OP_SLEEP = 6'h27,
    OP_TABLE = 6'h28, OP_MOVF = 6'h29
  } ebcod_op_t;

  // Flag update masks, order {C, DC, Z, OV, N}
  localparam logic [4:0]  FL_ARITH          = 5'h1F;
  localparam logic [4:0]  FL_LOGIC          = 5'h05;
  localparam logic [4:0]  FL_NONE           = 5'h00;

  // Bit positions of status vector {C, DC, Z, OV, N}
  localparam int          S_C = 4;
  localparam int          S_Z = 2;
  localparam int          S_OV = 1;
  localparam int          S_N = 0;

  // Address of the timer-zero count in the access view
  localparam logic [11:0] A_TIMER_ZERO      = 12'hFD6;

endpackage : ebcod_pkg

/* File: src/ebcod_phase.sv */
// Instruction cycle phase divider: four oscillator periods per cycle.
// Assumes one free-running core clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module ebcod_phase
  import ebcod_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // Phase outputs
  output logic      [1:0] phase_o,
  output logic            cyc_end_o
);

  logic [1:0] ph_q;
  logic [1:0] ph_d;

  // Next phase wraps after the write phase
  always_comb begin
    ph_d = (ph_q == PHASE_LAST) ? 2'h0 : 2'(ph_q + 2'h1);
  end

  // Phase register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ph_q <= 2'h0;
    end else begin
      ph_q <= ph_d;
    end
  end

  assign phase_o   = ph_q;
  assign cyc_end_o = (ph_q == PHASE_LAST);

endmodule : ebcod_phase
`default_nettype wire

/* File: src/ebcod_top.sv */
// Opcode decoder of the 8-bit accumulator core: classifies each fetched word,
// extracts operand fields, and drives cycle and side-effect strobes.
// Assumes the fetch path presents a new word that is held for a whole
// instruction cycle, qualified by FETCH_VALID_I at the cycle's last phase.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Access bit 0 selects access bank; 1 takes bank from bank select value.
// - Destination bit 0 writes accumulator; 1 writes back to file register.
// - Bit ops carry a three-bit field selecting bit 0 to 7.
// - File operand is 8-bit; file-to-file move uses 12-bit addresses.
// - Table mode selects keep, post-increment, post-decrement or pre-increment.
// - Fast bit selects saving or restoring shadow registers on call/return.
// - Add, add-carry, subtract, increment, decrement, negate update all five flags.
// - And, or, xor, complement update only zero and negative flags.
// - Compare-and-skip ops skip on equal, greater or less; no flags.
// - File-to-file move is two words, two cycles, 12-bit source and destination.
// - Word with upper nibble 1111 alone runs as no-operation.
// - Bit clear, set, toggle, test-skip-clear, test-skip-set change no flags.
// - Conditional branches on eight conditions; one cycle, two when taken.
// - Absolute call and jump are two words with a 20-bit target.
// - Fixed words decode nop, watchdog clear, push, pop, decimal adjust, reset.
// - Interrupt return re-enables interrupts; returns take two cycles.
// - Watchdog clear and standby update timeout/powerdown flags; reset affects all.
// - Increment/decrement-and-skip variants decode and leave flags untouched.
// - Changed program counter or true test adds a no-operation cycle.
// - Write-back to timer-zero count clears its prescaler if assigned.
// - Read-modify-write of a port uses pin levels, not latch contents.
// - Each instruction cycle spans four oscillator periods.
module ebcod_top
  import ebcod_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RSTN_I,
  // Fetch path
  input  wire logic [15:0] FETCH_WORD_I,
  input  wire logic        FETCH_VALID_I,
  // Core status used by branch, skip, addressing and side-effect decisions
  input  wire logic  [4:0] ALU_STATUS_I,
  input  wire logic        SKIP_TRUE_I,
  input  wire logic  [7:0] BANK_SELECT_VALUE_I,
  input  wire logic        TIMER_ZERO_COUNT_PRESCALE_ASSIGNED_I,
  input  wire logic        PORT_TARGET_I,
  // Decoded operation
  output logic       [5:0] OP_CLASS_O,
  output logic      [11:0] SRC_ADDR_O,
  output logic      [11:0] DST_ADDR_O,
  output logic             DEST_FILE_O,
  output logic       [2:0] BIT_SEL_O,
  output logic      [19:0] TARGET_O,
  output logic       [1:0] TABLE_MODE_O,
  output logic             FAST_O,
  output logic       [7:0] LITERAL_O,
  output logic       [4:0] FLAG_MASK_O,
  // Cycle control
  output logic       [1:0] PHASE_O,
  output logic             EXEC_O,
  output logic             FLUSH_O,
  output logic             PORT_READ_PINS_O,
  // Side-effect strobes
  output logic             IRQ_ENABLE_SET_O,
  output logic             WDT_STATUS_UPD_O,
  output logic             SLEEP_O,
  output logic             SWRESET_O,
  output logic             PRESCALE_CLR_O
);

  typedef enum logic [1:0] {
    ST_DECODE = 2'b00,
    ST_SECOND = 2'b01,
    ST_FLUSH  = 2'b10
  } ebcod_st_t;

  logic       [1:0] phase;
  logic             cyc_end;
  ebcod_st_t        st_q, st_d;
  ebcod_op_t        op_q, op_d, dec_op;
  logic      [11:0] src_q, src_d, dst_q, dst_d;
  logic             dest_q, dest_d;
  logic       [2:0] bit_q, bit_d;
  logic      [19:0] tgt_q, tgt_d;
  logic       [1:0] tbl_q, tbl_d;
  logic             fast_q, fast_d;
  logic       [7:0] lit_q, lit_d;
  logic       [4:0] fl_q, fl_d;
  logic             exec_q, exec_d, flush_q, flush_d;
  logic             gie_q, gie_d, wdt_q, wdt_d, slp_q, slp_d, rst_q, rst_d;
  logic             pre_q, pre_d, pin_q, pin_d;
  logic       [3:0] cond;
  logic             cond_true, two_word, pc_change, writes_file;
  logic      [11:0] bank_addr;
  logic      [15:0] w;

  // Four-period instruction cycle timing
  ebcod_phase u_phase (
    .clk_i     (MCLK_I),
    .rstn_i    (RSTN_I),
    .phase_o   (phase),
    .cyc_end_o (cyc_end)
  );

  assign w = FETCH_WORD_I;

  // Combinational classification of a first word
  always_comb begin
    dec_op = OP_NOP; // Unlisted codes fall to no-operation
    if (w == W_NOP) dec_op = OP_NOP;
    else if (w == W_WDT_CLEAR) dec_op = OP_WDT;
    else if (w == W_PUSH) dec_op = OP_PUSH;
    else if (w == W_POP) dec_op = OP_POP;
    else if (w == W_DAW) dec_op = OP_DAW;
    else if (w == W_SLEEP) dec_op = OP_SLEEP;
    else if (w == W_SWRESET) dec_op = OP_RESET;
    else if (w[15:1] == W_INTERRUPT_RETURN_OP_HI) dec_op = OP_INTERRUPT_RETURN_OP;
    else if (w[15:1] == W_RETURN_HI) dec_op = OP_RETURN;
    else if (w[15:2] == {8'h00, B_TABLE}) dec_op = OP_TABLE;
    else if (w[15:8] == B_RETURN_WITH_LITERAL_OP) dec_op = OP_RETURN_WITH_LITERAL_OP;
    else if (w[15:12] == N_SECOND) dec_op = OP_NOP; // Lone second word
    else if (w[15:12] == N_MOVE) dec_op = OP_FILE_TO_FILE_MOVE;
    else if (w[15:12] == N_REL) dec_op = w[11] ? OP_RELATIVE_SUBROUTINE_CALL : OP_BRA;
    else if (w[15:8] == B_ABSOLUTE_JUMP) dec_op = OP_ABSOLUTE_JUMP;
    else if (w[15:9] == B_CALL) dec_op = OP_CALL;
    else if (w[15:12] == N_BRANCH && !w[11]) dec_op = OP_BCOND;
    else begin
      unique case (w[15:10])
        6'b001001: dec_op = OP_ADD;
        6'b001000: dec_op = OP_ADDC;
        6'b010111: dec_op = OP_SUB;
        6'b010110: dec_op = OP_SUBB;
        6'b010101: dec_op = OP_SUBFB;
        6'b001010: dec_op = OP_INC;
        6'b000001: dec_op = OP_DEC;
        6'b000101: dec_op = OP_AND;
        6'b000100: dec_op = OP_IOR;
        6'b000110: dec_op = OP_XOR;
        6'b000111: dec_op = OP_COM;
        6'b001011: dec_op = OP_DECSZ;
        6'b001111: dec_op = OP_INCSZ;
        6'b010011: dec_op = OP_DECSNZ;
        6'b010010: dec_op = OP_INCSNZ;
        6'b010100: dec_op = OP_MOVF;
        6'b011011: dec_op = w[9] ? OP_NOP : OP_NEG;
        6'b011000: begin // Compare-and-skip group
          unique case (w[9])
            1'b0: dec_op = OP_CPSLT;
            1'b1: dec_op = OP_CPSEQ;
          endcase
        end
        6'b011001: dec_op = w[9] ? OP_NOP : OP_CPSGT;
        default: begin
          unique case (w[15:12]) // Bit-oriented group
            4'b1001: dec_op = OP_BCLR;
            4'b1000: dec_op = OP_BSET;
            4'b0111: dec_op = OP_BTGL;
            4'b1011: dec_op = OP_BTSC;
            4'b1010: dec_op = OP_BTSS;
            default: dec_op = OP_NOP;
          endcase
        end
      endcase
    end
  end

  // Branch condition evaluation against core status
  assign cond = w[11:8];
  always_comb begin
    unique case (cond[2:1])
      2'b00: cond_true = ALU_STATUS_I[S_Z] ^ cond[0];
      2'b01: cond_true = ALU_STATUS_I[S_C] ^ cond[0];
      2'b10: cond_true = ALU_STATUS_I[S_OV] ^ cond[0];
      2'b11: cond_true = ALU_STATUS_I[S_N] ^ cond[0];
    endcase
  end

  // Bank-qualified 12-bit address of an 8-bit operand
  assign bank_addr = w[F_ACCESS] ? {BANK_SELECT_VALUE_I[3:0], w[7:0]}
                                 : {{4{w[7]}}, w[7:0]};

  assign two_word  = (dec_op == OP_FILE_TO_FILE_MOVE) || (dec_op == OP_CALL) || (dec_op == OP_ABSOLUTE_JUMP);
  assign pc_change = (dec_op == OP_BRA) || (dec_op == OP_RELATIVE_SUBROUTINE_CALL) || (dec_op == OP_INTERRUPT_RETURN_OP)
                  || (dec_op == OP_RETURN) || (dec_op == OP_RETURN_WITH_LITERAL_OP)
                  || ((dec_op == OP_BCOND) && cond_true);
  assign writes_file = (w[F_DEST] && (dec_op inside {OP_ADD, OP_ADDC, OP_SUB, OP_SUBB,
                  OP_SUBFB, OP_INC, OP_DEC, OP_AND, OP_IOR, OP_XOR, OP_COM, OP_DECSZ,
                  OP_INCSZ, OP_DECSNZ, OP_INCSNZ}))
                  || (dec_op inside {OP_BCLR, OP_BSET, OP_BTGL}); // Bit clear, set and toggle always write back

  // Next-state and output-register computation, once per instruction cycle
  always_comb begin
    st_d = st_q;   op_d = op_q;   src_d = src_q;  dst_d = dst_q;
    dest_d = dest_q; bit_d = bit_q; tgt_d = tgt_q; tbl_d = tbl_q;
    fast_d = fast_q; lit_d = lit_q; fl_d = fl_q;
    exec_d = 1'b0; flush_d = 1'b0; gie_d = 1'b0; wdt_d = 1'b0;
    slp_d = 1'b0; rst_d = 1'b0; pre_d = 1'b0; pin_d = 1'b0;
    if (cyc_end && FETCH_VALID_I) begin
      unique case (st_q)
        ST_DECODE: begin
          op_d   = dec_op;
          src_d  = bank_addr;
          dst_d  = bank_addr;
          dest_d = w[F_DEST];
          bit_d  = w[F_BIT_LSB +: 3];
          lit_d  = w[7:0];
          tbl_d  = w[1:0];
          fast_d = (dec_op == OP_CALL) ? w[F_CALL_FAST] : w[F_FAST];
          tgt_d  = {{12{w[7]}}, w[7:0]};
          if (dec_op == OP_BRA || dec_op == OP_RELATIVE_SUBROUTINE_CALL) begin
            tgt_d = {{9{w[10]}}, w[10:0]};
          end
          if (dec_op == OP_FILE_TO_FILE_MOVE) begin
            src_d = w[11:0];
          end
          if (dec_op == OP_CALL || dec_op == OP_ABSOLUTE_JUMP) begin
            tgt_d = {12'h000, w[7:0]};
          end
          unique case (dec_op)
            OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_SUBFB, OP_INC, OP_DEC, OP_NEG:
              fl_d = FL_ARITH;
            OP_AND, OP_IOR, OP_XOR, OP_COM, OP_MOVF: fl_d = FL_LOGIC;
            default: fl_d = FL_NONE;
          endcase
          exec_d = !two_word;
          gie_d  = (dec_op == OP_INTERRUPT_RETURN_OP);
          wdt_d  = (dec_op == OP_WDT) || (dec_op == OP_SLEEP);
          slp_d  = (dec_op == OP_SLEEP);
          rst_d  = (dec_op == OP_RESET);
          pre_d  = writes_file && (bank_addr == A_TIMER_ZERO)
                && TIMER_ZERO_COUNT_PRESCALE_ASSIGNED_I;
          pin_d  = writes_file && PORT_TARGET_I;
          if (two_word) st_d = ST_SECOND;
          else if (pc_change) st_d = ST_FLUSH;
        end
        ST_SECOND: begin
          if (op_q == OP_FILE_TO_FILE_MOVE) dst_d = w[11:0];
          else tgt_d = {w[11:0], tgt_q[7:0]};
          exec_d = 1'b1;
          st_d   = ST_DECODE;
        end
        ST_FLUSH: begin
          flush_d = 1'b1; // Extra cycle runs as no-operation
          st_d    = ST_DECODE;
        end
        default: st_d = ST_DECODE;
      endcase
    end
    // A skip resolved by the datapath costs one flush cycle
    if (exec_q && SKIP_TRUE_I && st_q == ST_DECODE && !cyc_end) st_d = ST_FLUSH;
  end

  // Register stage, synchronous reset
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      st_q <= ST_DECODE; op_q <= OP_NOP; src_q <= 12'h000; dst_q <= 12'h000;
      dest_q <= 1'b0; bit_q <= 3'h0; tgt_q <= 20'h00000; tbl_q <= 2'h0;
      fast_q <= 1'b0; lit_q <= 8'h00; fl_q <= 5'h00; exec_q <= 1'b0;
      flush_q <= 1'b0; gie_q <= 1'b0; wdt_q <= 1'b0; slp_q <= 1'b0;
      rst_q <= 1'b0; pre_q <= 1'b0; pin_q <= 1'b0;
    end else begin
      st_q <= st_d; op_q <= op_d; src_q <= src_d; dst_q <= dst_d;
      dest_q <= dest_d; bit_q <= bit_d; tgt_q <= tgt_d; tbl_q <= tbl_d;
      fast_q <= fast_d; lit_q <= lit_d; fl_q <= fl_d; exec_q <= exec_d;
      flush_q <= flush_d; gie_q <= gie_d; wdt_q <= wdt_d; slp_q <= slp_d;
      rst_q <= rst_d; pre_q <= pre_d; pin_q <= pin_d;
    end
  end

  // Outputs, all from registers except the phase
  assign OP_CLASS_O = op_q;       assign SRC_ADDR_O = src_q;
  assign DST_ADDR_O = dst_q;      assign DEST_FILE_O = dest_q;
  assign BIT_SEL_O = bit_q;       assign TARGET_O = tgt_q;
  assign TABLE_MODE_O = tbl_q;    assign FAST_O = fast_q;
  assign LITERAL_O = lit_q;       assign FLAG_MASK_O = fl_q;
  assign PHASE_O = phase;         assign EXEC_O = exec_q;
  assign FLUSH_O = flush_q;       assign PORT_READ_PINS_O = pin_q;
  assign IRQ_ENABLE_SET_O = gie_q; assign WDT_STATUS_UPD_O = wdt_q;
  assign SLEEP_O = slp_q;         assign SWRESET_O = rst_q;
  assign PRESCALE_CLR_O = pre_q;

  // Checks
  property p_logic_flags;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (exec_q && (op_q inside {OP_AND, OP_IOR, OP_XOR, OP_COM})) |-> fl_q == FL_LOGIC;
  endproperty
  a_logic_flags: assert property (p_logic_flags) else $error("logic flags wrong");

  property p_arith_flags;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (exec_q && (op_q inside {OP_ADD, OP_ADDC, OP_INC, OP_DEC})) |-> fl_q == FL_ARITH;
  endproperty
  a_arith_flags: assert property (p_arith_flags) else $error("arith flags wrong");

  property p_no_flag_bit;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (exec_q && (op_q inside {OP_BCLR, OP_BSET, OP_BTGL, OP_CPSEQ, OP_DECSZ})) |-> fl_q == 5'h00;
  endproperty
  a_no_flag_bit: assert property (p_no_flag_bit) else $error("flags on bit op");

  property p_two_word;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (st_q == ST_SECOND) |-> ##[1:4] (exec_q && st_q == ST_DECODE) or (st_q == ST_SECOND) [*4];
  endproperty
  a_two_word: assert property (p_two_word) else $error("second word lost");

  property p_flush_follows;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    flush_q |-> $past(st_q) == ST_FLUSH;
  endproperty
  a_flush_follows: assert property (p_flush_follows) else $error("stray flush");

  property p_interrupt_return_op_gie;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    gie_q |-> op_q == OP_INTERRUPT_RETURN_OP && st_q == ST_FLUSH;
  endproperty
  a_interrupt_return_op_gie: assert property (p_interrupt_return_op_gie) else $error("enable without return");

  property p_wdt_status;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    wdt_q |-> (op_q == OP_WDT || op_q == OP_SLEEP);
  endproperty
  a_wdt_status: assert property (p_wdt_status) else $error("bad status update");

  property p_cycle_len;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    cyc_end |=> !cyc_end [*3] ##1 cyc_end;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("cycle not four periods");

  property p_prescale;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    pre_q |-> src_q == A_TIMER_ZERO && (dest_q || op_q inside {OP_BCLR, OP_BSET, OP_BTGL});
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler clear wrong");

endmodule : ebcod_top
`default_nettype wire

/* File: testbench/ebcod_fetch_model.sv */
// Fetch path model: hands the decoder one program word per instruction cycle.
// Assumes the decoder takes the word at the last phase of each cycle.
`timescale 1ns/100ps
`default_nettype none
module ebcod_fetch_model (
  // Clock and phase
  input  wire logic        clk_i,
  input  wire logic  [1:0] phase_i,
  // Word asked for by the bench
  input  wire logic [15:0] word_i,
  input  wire logic        valid_i,
  // Fetch outputs
  output logic      [15:0] fetch_word_o,
  output logic             fetch_valid_o
);
  // Start values, so the decoder never sees an unknown word
  initial begin
    fetch_word_o  = 16'h0000;
    fetch_valid_o = 1'b0;
  end
  // Load at cycle start and hold; an idle slot shows a changing pattern
  always @(posedge clk_i) begin
    if (phase_i == 2'h0) begin
      fetch_valid_o <= valid_i;
      fetch_word_o  <= valid_i ? word_i : ~fetch_word_o;
    end
  end
endmodule // ebcod_fetch_model
`default_nettype wire

/* File: testbench/ebcod_top_tb.sv */
// Self-checking bench of the opcode decoder: corner cases, then a random word stream.
// Assumes the fetch model and a reference of expected decode kept in this module.
`timescale 1ns/100ps
`default_nettype none
module ebcod_top_tb
  import ebcod_pkg::*;
;
  typedef struct packed {
    logic [15:0] v;
    logic [15:0] m;
    logic [5:0]  op;
    logic [5:0]  fm;
    logic [3:0]  k;
  } ebcod_tpl_t;
  logic        mclk, rstn, valid, fvalid, skip, asg, prt, dfile, fast, exec, flush;
  logic        pins, irq, wdt, slp, swr, pre;
  logic [15:0] word, fword;
  logic [4:0]  st, fmask;
  logic [7:0]  bank, lit;
  logic [5:0]  op_c;
  logic [11:0] src, dst;
  logic [19:0] tgt;
  logic [2:0]  bsel;
  logic [1:0]  tmode, phase;
  int          seed, fails, num_checks, pend, di[14];
  logic        fl;
  logic [15:0] w1, dw[14];
  ebcod_top i_ebcod_top (.MCLK_I(mclk), .RSTN_I(rstn), .FETCH_WORD_I(fword),
    .FETCH_VALID_I(fvalid), .ALU_STATUS_I(st), .SKIP_TRUE_I(skip),
    .BANK_SELECT_VALUE_I(bank), .TIMER_ZERO_COUNT_PRESCALE_ASSIGNED_I(asg), .PORT_TARGET_I(prt),
    .OP_CLASS_O(op_c), .SRC_ADDR_O(src), .DST_ADDR_O(dst), .DEST_FILE_O(dfile),
    .BIT_SEL_O(bsel), .TARGET_O(tgt), .TABLE_MODE_O(tmode), .FAST_O(fast),
    .LITERAL_O(lit), .FLAG_MASK_O(fmask), .PHASE_O(phase), .EXEC_O(exec),
    .FLUSH_O(flush), .PORT_READ_PINS_O(pins), .IRQ_ENABLE_SET_O(irq),
    .WDT_STATUS_UPD_O(wdt), .SLEEP_O(slp), .SWRESET_O(swr), .PRESCALE_CLR_O(pre));
  ebcod_fetch_model i_ebcod_fetch_model (.clk_i(mclk), .phase_i(phase), .word_i(word),
    .valid_i(valid), .fetch_word_o(fword), .fetch_valid_o(fvalid));
  // 20 MHz core clock
  always #25 mclk = ~mclk;
  // Word templates: value, random bits, class, flag mask (bit 5 = check), field kind
  function automatic ebcod_tpl_t tpl(input int i);
    case (i)
      0: tpl = '{16'h2400, 16'h03FF, OP_ADD, 6'h3F, 4'h1};
      1: tpl = '{16'h2000, 16'h03FF, OP_ADDC, 6'h3F, 4'h1};
      2: tpl = '{16'h2800, 16'h03FF, OP_INC, 6'h3F, 4'h1};
      3: tpl = '{16'h0400, 16'h03FF, OP_DEC, 6'h3F, 4'h1};
      4: tpl = '{16'h6D00, 16'h00FF, OP_NEG, 6'h3F, 4'h0};
      5: tpl = '{16'h1400, 16'h03FF, OP_AND, 6'h25, 4'h1};
      6: tpl = '{16'h1000, 16'h03FF, OP_IOR, 6'h25, 4'h1};
      7: tpl = '{16'h1800, 16'h03FF, OP_XOR, 6'h25, 4'h1};
      8: tpl = '{16'h1C00, 16'h03FF, OP_COM, 6'h25, 4'h1};
      9: tpl = '{16'h6200, 16'h01FF, OP_CPSEQ, 6'h20, 4'h2};
      10: tpl = '{16'h6400, 16'h01FF, OP_CPSGT, 6'h20, 4'h2};
      11: tpl = '{16'h6000, 16'h01FF, OP_CPSLT, 6'h20, 4'h2};
      12: tpl = '{16'h2C00, 16'h03FF, OP_DECSZ, 6'h20, 4'h1};
      13: tpl = '{16'h3C00, 16'h03FF, OP_INCSZ, 6'h20, 4'h1};
      14: tpl = '{16'h4C00, 16'h03FF, OP_DECSNZ, 6'h20, 4'h1};
      15: tpl = '{16'h4800, 16'h03FF, OP_INCSNZ, 6'h20, 4'h1};
      16: tpl = '{16'h9000, 16'h0FFF, OP_BCLR, 6'h20, 4'h3};
      17: tpl = '{16'h8000, 16'h0FFF, OP_BSET, 6'h20, 4'h3};
      18: tpl = '{16'h7000, 16'h0FFF, OP_BTGL, 6'h20, 4'h3};
      19: tpl = '{16'hB000, 16'h0FFF, OP_BTSC, 6'h20, 4'h4};
      20: tpl = '{16'hA000, 16'h0FFF, OP_BTSS, 6'h20, 4'h4};
      21: tpl = '{16'hE000, 16'h07FF, OP_BCOND, 6'h20, 4'h5};
      22: tpl = '{16'hD000, 16'h07FF, OP_BRA, 6'h20, 4'h6};
      23: tpl = '{16'hD800, 16'h07FF, OP_RELATIVE_SUBROUTINE_CALL, 6'h20, 4'h6};
      24: tpl = '{16'h0004, 16'h0000, OP_WDT, 6'h00, 4'h0};
      25: tpl = '{16'h0003, 16'h0000, OP_SLEEP, 6'h00, 4'h0};
      26: tpl = '{16'h0005, 16'h0000, OP_PUSH, 6'h20, 4'h0};
      27: tpl = '{16'h0006, 16'h0000, OP_POP, 6'h20, 4'h0};
      28: tpl = '{16'h0007, 16'h0000, OP_DAW, 6'h20, 4'h0};
      29: tpl = '{16'h0000, 16'h0000, OP_NOP, 6'h20, 4'h0};
      30: tpl = '{16'h0010, 16'h0001, OP_INTERRUPT_RETURN_OP, 6'h00, 4'h7};
      31: tpl = '{16'h0012, 16'h0001, OP_RETURN, 6'h20, 4'h7};
      32: tpl = '{16'h0C00, 16'h00FF, OP_RETURN_WITH_LITERAL_OP, 6'h20, 4'h8};
      33: tpl = '{16'hF000, 16'h0FFF, OP_NOP, 6'h20, 4'h0};
      34: tpl = '{16'h0008, 16'h0003, OP_TABLE, 6'h20, 4'h9};
      35: tpl = '{16'hC000, 16'h0FFF, OP_FILE_TO_FILE_MOVE, 6'h20, 4'hA};
      36: tpl = '{16'hEF00, 16'h00FF, OP_ABSOLUTE_JUMP, 6'h20, 4'hB};
      37: tpl = '{16'hEC00, 16'h01FF, OP_CALL, 6'h20, 4'hB};
      38: tpl = '{16'h00FF, 16'h0000, OP_RESET, 6'h00, 4'h0};
      default: tpl = '{16'h0001, 16'h0000, OP_NOP, 6'h20, 4'h0};
    endcase
  endfunction
  // Branch condition from ccc and the {C,DC,Z,OV,N} status
  function automatic logic taken(input logic [2:0] c, input logic [4:0] s);
    case (c[2:1])
      2'h0: taken = s[S_Z];
      2'h1: taken = s[S_C];
      2'h2: taken = s[S_OV];
      default: taken = s[S_N];
    endcase
    taken = taken ^ c[0];
  endfunction
  task automatic chk(input logic [19:0] s, input logic [19:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One instruction cycle: present a word, then compare the decode against the reference
  task automatic step(input int i, input logic [15:0] w, input logic v);
    ebcod_tpl_t t;
    logic [11:0] a;
    logic [4:0] s;
    logic [7:0] b;
    logic k, g, e, md, tk;
    t = tpl(pend >= 0 ? pend : i);
    for (int n = 0; n < 4 && phase !== 2'h0; n++) begin
      @(posedge mclk);
      #1;
    end
    chk(phase, 2'h0);
    word = w;
    valid = v;
    s = 5'($random(seed));
    // Datapath raises its skip result only for test-and-skip operations
    k = 1'($random(seed)) && (t.op inside {[OP_CPSEQ:OP_INCSNZ], OP_BTSC, OP_BTSS});
    b = 8'($random(seed)) & 8'h07;
    g = 1'($random(seed));
    @(posedge mclk);
    st <= s;
    skip <= k;
    bank <= b;
    asg <= g;
    prt <= g;
    #1;
    chk({exec, flush}, 2'h0);
    repeat (3) @(posedge mclk);
    #1;
    a = w[8] ? {b[3:0], w[7:0]} : {{4{w[7]}}, w[7:0]};
    e = 1'b0;
    md = 1'b0;
    tk = 1'b0;
    if (!v) chk({exec, flush}, 2'h0);
    else if (fl) begin
      chk({exec, flush}, 2'h1);
      fl = 1'b0;
    end else if (pend < 0 && t.k > 4'h9) begin
      chk({exec, flush}, 2'h0);
      pend = i;
      w1 = w;
    end else begin
      e = 1'b1;
      chk({exec, flush}, 2'h2);
      chk(op_c, t.op);
      if (t.fm[5]) chk(fmask, t.fm[4:0]);
      if (t.k inside {4'h1, 4'h2, 4'h3, 4'h4}) chk(src, a);
      if (t.k inside {4'h3, 4'h4}) chk(bsel, w[11:9]);
      case (t.k)
        4'h1: chk(dfile, w[9]);
        4'h5: chk(tgt, {{12{w[7]}}, w[7:0]});
        4'h6: chk(tgt, {{9{w[10]}}, w[10:0]});
        4'h7: chk(fast, w[0]);
        4'h8: chk(lit, w[7:0]);
        4'h9: chk(tmode, w[1:0]);
        4'hA: begin
          chk(src, w1[11:0]);
          chk(dst, w[11:0]);
        end
        4'hB: chk(tgt, {w[11:0], w1[7:0]});
        default: ;
      endcase
      if (t.op == OP_CALL) chk(fast, w1[F_CALL_FAST]);
      md = (t.k == 4'h1) ? w[9] : (t.k == 4'h3);
      tk = (t.k inside {4'h6, 4'h7, 4'h8}) || (t.k == 4'h5 && taken(w[10:8], s));
      fl = tk || (k && t.op inside {[OP_CPSEQ:OP_INCSNZ], OP_BTSC, OP_BTSS});
      pend = -1;
    end
    chk(wdt, e && (t.op == OP_WDT || t.op == OP_SLEEP));
    chk(slp, e && t.op == OP_SLEEP);
    chk(irq, e && t.op == OP_INTERRUPT_RETURN_OP);
    chk(swr, e && t.op == OP_RESET);
    chk(pre, e && md && a == A_TIMER_ZERO && g);
    chk(pins, e && md && g);
  endtask
  // Cut a hang short: about 430 cycles of four clocks fit well inside this
  initial begin
    repeat (4000) @(posedge mclk);
    fails++;
    finish_test();
  end
  // Main sequence
  initial begin
    ebcod_tpl_t t;
    logic [15:0] w;
    int i;
    {mclk, rstn, valid, skip, asg, prt, word, st, bank} = '0;
    {seed, fails, num_checks, pend, fl} = {32'd49, 32'd0, 32'd0, -32'sd1, 1'b0};
    di = '{0, 35, 35, 36, 36, 29, 37, 37, 0, 35, -1, 35, 33, 99};
    dw = '{16'h2401, 16'hC123, 16'hF456, 16'hEF12, 16'hF345, 16'h0000, 16'hED34,
           16'hFABC, 16'h2401, 16'hC0AA, 16'h1234, 16'hF0BB, 16'hF7E5, 16'h0001};
    repeat (8) @(posedge mclk);
    #1;
    chk({exec, op_c, phase}, 9'h000);
    @(posedge mclk);
    rstn <= 1'b1;
    for (int n = 0; n < 14; n++) step(di[n], dw[n], di[n] >= 0);
    $display("directed cases done");
    for (int n = 0; n < 400; n++) begin
      i = $unsigned($random(seed)) % 38;
      t = tpl(i);
      w = t.v | (16'($random(seed)) & t.m);
      if (t.k inside {4'h1, 4'h3} && $random(seed) % 6 == 0) w[8:0] = 9'h0D6;
      if (pend >= 0) w = 16'hF000 | {4'h0, w[11:0]};
      step(i, w, $random(seed) % 8 != 0);
    end
    $display("random stream done");
    // Spend a pending second word or flush so the reset word really decodes
    if (pend >= 0 || fl) step(33, 16'hF000, 1'b1);
    step(38, 16'h00FF, 1'b1);
    valid = 1'b0;
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk({exec, flush, op_c, phase}, 10'h000);
    @(posedge mclk);
    rstn <= 1'b1;
    {pend, fl} = {-32'sd1, 1'b0};
    step(0, 16'h2401, 1'b1);
    $display("reset cases done");
    finish_test();
  end
endmodule // ebcod_top_tb
`default_nettype wire
